// *** rrg_clockgen.sv ***
// Clock generator end: ready merging, reset synchroniser, peripheral clock.
// Assumes the processor end drives status and ready inputs from logic on
// the same clock; the asynchronous ready and reset request are foreign.
//
// Function
// [R1] Async ready sampled at start of command state.
// [R2] Async ready low drives ready after phase 1.
// [R3] Wait state only when both inputs inactive/disabled.
// [R4] Async resolved active: ignore sync ready.
// [R5] Ready output only pulls low or floats.
// [R6] Status line low releases ready output.
// [R7] Ready held low until cycle start/input high.
// [R8] Ready held low during reset.
// [R9] Single-wait chain drives sync ready.
// [R10] Chain inserts zero to three wait states.
// [R11] Non-local addresses disable sync ready.
// [R12] Transfer acknowledge drives async ready input.
// [R13] Processor idles in reset, restarts after.
// [R14] Reset output from request, falling edge aligned.
// [R15] Reset request held sixteen processor clocks.
// [R16] Reset clears processor phase, phase 2 follows.
// [R17] Peripheral clock aligned at first bus cycle.
// [R18] Reset request synchronised, one-two clock latency.
// [R19] Sync ready sampled end of phase 1.
// [R20] Async ready or enable high during status.
// [R21] Peripheral clock half rate, even duty.
// [R22] Bus state tracked from status lines.
`timescale 1ns/1ps

module rrg_clockgen
	import rrg_pkg::*;
(
	// System clock and synchronous reset.
	input  wire logic CLOCK,
	input  wire logic RESET,
	// Reset request pin, asynchronous, active low.
	input  wire logic RESET_REQUEST_N,
	// Clock and reset outputs to the rest of the system.
	output logic      PERIPH_CLK,
	output logic      SYSTEM_RESET,
	// Local bus link.
	rrg_bus_if.clockgen BUS
);

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------

	logic       req_meta_reg;
	logic       req_meta_next;
	logic       reset_out_reg;
	logic       reset_out_next;
	logic       async_meta_reg;
	logic       async_meta_next;
	logic       async_sync_reg;
	logic       async_sync_next;
	rrg_state_e state_reg;
	rrg_state_e state_next;
	logic       async_sample_reg;
	logic       async_sample_next;
	logic       async_won_reg;
	logic       async_won_next;
	logic       ready_oe_reg;
	logic       ready_oe_next;
	logic       pclk_reg;
	logic       pclk_next;
	logic       aligned_reg;
	logic       aligned_next;
	logic       cycle_start;
	logic       enter_tc;
	logic       sync_hit;
	logic       sel_high;

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------

	// The second reset stage is itself the reset output, which keeps the
	// latency at two clocks and aligns both of its edges to the clock.
	always_comb
	begin
		req_meta_next   = RESET_REQUEST_N;
		reset_out_next  = ~req_meta_reg;          // [R14] [R18]
		async_meta_next = BUS.async_ready_in_n;
		async_sync_next = async_meta_reg;
	end

	// Registers the synchroniser stages.
	always_ff @(posedge CLOCK)
	begin
		if (RESET)
		begin
			req_meta_reg   <= 1'h0;
			reset_out_reg  <= RRG_RESET_OUT_INIT;
			async_meta_reg <= 1'h1;
			async_sync_reg <= 1'h1;
		end
		else
		begin
			req_meta_reg   <= req_meta_next;
			reset_out_reg  <= reset_out_next;
			async_meta_reg <= async_meta_next;
			async_sync_reg <= async_sync_next;
		end
	end

	// ------------------------------------------------------------------
	// Bus state tracking
	// ------------------------------------------------------------------

	// A cycle starts when either status line is low while the bus is idle.
	assign cycle_start = (~BUS.bus_status_hi_n | ~BUS.bus_status_lo_n) &&
		(state_reg == RRG_IDLE);                  // [R22] [R6]
	// A command state begins after status or after a wait state.
	assign enter_tc = (state_reg == RRG_TS2) ||
		((state_reg == RRG_TC2) && !ready_oe_reg);

	// Next bus state; the status-low cycle itself is phase 1 of status.
	always_comb
	begin
		state_next = state_reg;
		if (reset_out_reg)
			state_next = RRG_IDLE;
		else
		begin
			unique case (state_reg)
				RRG_IDLE: if (cycle_start) state_next = RRG_TS2;
				RRG_TS1:  state_next = RRG_TS2;
				RRG_TS2:  state_next = RRG_TC1;
				RRG_TC1:  state_next = RRG_TC2;
				RRG_TC2:
				begin
					// Ready low terminates, otherwise a wait state.
					if (ready_oe_reg)
						state_next = RRG_IDLE; // [R22]
					else
						state_next = RRG_TC1;  // [R3]
				end
				default:  state_next = RRG_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Ready merging
	// ------------------------------------------------------------------

	// Sync ready counts only while the async path has not won the cycle.
	assign sync_hit = ~BUS.sync_ready_enable_n & ~BUS.sync_ready_in_n &
		~async_won_reg;                           // [R19] [R4]
	// The selected input is seen inactive again.
	assign sel_high = (~BUS.sync_ready_enable_n & BUS.sync_ready_in_n) |
		(~BUS.async_ready_enable_n & async_sync_reg);

	// Samples async ready at each command start and drives the pull-down.
	always_comb
	begin
		async_sample_next = async_sample_reg;
		async_won_next    = async_won_reg;
		ready_oe_next     = ready_oe_reg;
		if (cycle_start)
		begin
			async_sample_next = 1'h0;
			async_won_next    = 1'h0;
		end
		else if (enter_tc)
			async_sample_next = ~BUS.async_ready_enable_n &
				~async_sync_reg;                  // [R1] [R12]
		if ((state_reg == RRG_TC1) && async_sample_reg)
			async_won_next = 1'h1;                // [R4]
		if (reset_out_reg)
			ready_oe_next = 1'h1;                 // [R8]
		else if (cycle_start)
			ready_oe_next = 1'h0;                 // [R6]
		else if ((state_reg == RRG_TC1) && (async_sample_reg || sync_hit))
			ready_oe_next = 1'h1;                 // [R2] [R19] [R3]
		else if ((state_reg == RRG_IDLE) && ready_oe_reg && sel_high)
			ready_oe_next = 1'h0;                 // [R7]
	end

	// Registers the bus tracker and the ready pull-down.
	always_ff @(posedge CLOCK)
	begin
		if (RESET)
		begin
			state_reg        <= RRG_IDLE;
			async_sample_reg <= 1'h0;
			async_won_reg    <= 1'h0;
			ready_oe_reg     <= RRG_READY_OE_INIT;
		end
		else
		begin
			state_reg        <= state_next;
			async_sample_reg <= async_sample_next;
			async_won_reg    <= async_won_next;
			ready_oe_reg     <= ready_oe_next;
		end
	end

	// ------------------------------------------------------------------
	// Peripheral clock
	// ------------------------------------------------------------------

	// Free-running half-rate clock, snapped to the processor phase at the
	// first cycle start after reset; the start cycle is processor phase 1.
	always_comb
	begin
		pclk_next    = ~pclk_reg;                 // [R21]
		aligned_next = aligned_reg;
		if (reset_out_reg)
			aligned_next = 1'h0;
		else if (cycle_start && !aligned_reg)
		begin
			pclk_next    = RRG_PCLK_PH2;          // [R17]
			aligned_next = 1'h1;
		end
	end

	// Registers the peripheral clock and its alignment flag.
	always_ff @(posedge CLOCK)
	begin
		if (RESET)
		begin
			pclk_reg    <= RRG_PCLK_PH1;
			aligned_reg <= 1'h0;
		end
		else
		begin
			pclk_reg    <= pclk_next;
			aligned_reg <= aligned_next;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------

	// All outputs come straight from flip-flops; ready is open drain.
	assign PERIPH_CLK    = pclk_reg;
	assign SYSTEM_RESET  = reset_out_reg;
	assign BUS.cpu_reset = reset_out_reg;
	assign BUS.ready_oe  = ready_oe_reg;          // [R5]

endmodule

// *** rrg_pkg.sv ***
// Shared constants and types for the ready and reset generator link.
// Assumes one system clock drives both ends of the link.
package rrg_pkg;

	// ------------------------------------------------------------------
	// Bus state tracking
	// ------------------------------------------------------------------

	// Bus states, two system clocks (phase 1, phase 2) per state.
	typedef enum logic [2:0]
	{
		RRG_IDLE = 3'h0,
		RRG_TS1  = 3'h1,
		RRG_TS2  = 3'h2,
		RRG_TC1  = 3'h3,
		RRG_TC2  = 3'h4
	} rrg_state_e;

	// Processor clock phase encoding.
	localparam logic RRG_PHASE1 = 1'h0;
	localparam logic RRG_PHASE2 = 1'h1;

	// Peripheral clock level during processor phase 1 and phase 2.
	localparam logic RRG_PCLK_PH1 = 1'h1;
	localparam logic RRG_PCLK_PH2 = 1'h0;

	// ------------------------------------------------------------------
	// Wait-state chain and reset values
	// ------------------------------------------------------------------

	// Largest number of wait states the chain can insert.
	localparam int RRG_WAIT_MAX = 3;
	// One chain stage per wait state plus the zero-wait stage.
	localparam int RRG_CHAIN_LEN = RRG_WAIT_MAX + 1;
	localparam logic [RRG_CHAIN_LEN-1:0] RRG_CHAIN_RESET = 4'h0;

	// Reset value of the synchronised reset output.
	localparam logic RRG_RESET_OUT_INIT = 1'h1;
	// Reset value of the ready pull-down enable.
	localparam logic RRG_READY_OE_INIT = 1'h1;

endpackage

// *** rrg_bus_if.sv ***
// Local bus link between the clock generator end and the processor end.
// Assumes both ends run on the same system clock; the ready line has a
// pull-up, modelled here from the open-drain enable.
`timescale 1ns/1ps

interface rrg_bus_if;

	// Status lines, low marks a bus cycle start.
	logic bus_status_hi_n;
	logic bus_status_lo_n;
	// Ready inputs and their enables, all active low.
	logic sync_ready_in_n;
	logic sync_ready_enable_n;
	logic async_ready_in_n;
	logic async_ready_enable_n;
	// Open-drain ready pull-down enable and resolved line level.
	logic ready_oe;
	logic ready_n;
	// Synchronised processor reset, active high.
	logic cpu_reset;

	// Pull-up floats the line high unless the pull-down is enabled.
	assign ready_n = ~ready_oe;

	modport clockgen
	(
		input  bus_status_hi_n,
		input  bus_status_lo_n,
		input  sync_ready_in_n,
		input  sync_ready_enable_n,
		input  async_ready_in_n,
		input  async_ready_enable_n,
		output ready_oe,
		input  ready_n,
		output cpu_reset
	);

	modport cpu
	(
		output bus_status_hi_n,
		output bus_status_lo_n,
		output sync_ready_in_n,
		output sync_ready_enable_n,
		output async_ready_in_n,
		output async_ready_enable_n,
		input  ready_n,
		input  cpu_reset
	);

endinterface

// *** rrg_cpu_end.sv ***
// Processor end: status generation, wait-state chain and ready decode.
// Assumes the clock generator end shares the system clock and supplies
// the synchronised reset and the open-drain ready line.
`timescale 1ns/1ps

module rrg_cpu_end
	import rrg_pkg::*;
(
	// System clock and synchronous reset.
	input  wire logic       CLOCK,
	input  wire logic       RESET,
	// Bus cycle request from the user.
	input  wire logic       START,
	input  wire logic [1:0] WAIT_COUNT,
	input  wire logic       SYSTEM_BUS,
	// Transfer acknowledge from the system bus, active low.
	input  wire logic       XACK_N,
	// Cycle status to the user.
	output logic            BUSY,
	output logic            DONE,
	// Local bus link.
	rrg_bus_if.cpu          BUS
);

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------

	rrg_state_e               state_reg;
	rrg_state_e               state_next;
	logic                     phase_reg;
	logic                     phase_next;
	logic [RRG_CHAIN_LEN-1:0] chain_reg;
	logic [RRG_CHAIN_LEN-1:0] chain_next;
	logic [1:0]               count_reg;
	logic [1:0]               count_next;
	logic                     sys_reg;
	logic                     sys_next;
	logic                     status_n_reg;
	logic                     status_n_next;
	logic                     sync_ready_in_n_reg;
	logic                     sync_ready_in_n_next;
	logic                     sync_ready_in_en_n_reg;
	logic                     sync_ready_in_en_n_next;
	logic                     async_ready_in_en_n_reg;
	logic                     async_ready_in_en_n_next;
	logic                     xack_reg;
	logic                     done_reg;
	logic                     done_next;
	logic                     busy_reg;
	logic                     busy_next;
	logic                     in_tc_next;

	// ------------------------------------------------------------------
	// Bus sequencer
	// ------------------------------------------------------------------

	// Cycles start only on phase 1; reset idles and clears the phase.
	always_comb
	begin
		state_next = state_reg;
		count_next = count_reg;
		sys_next   = sys_reg;
		done_next  = 1'h0;
		phase_next = ~phase_reg;
		if (BUS.cpu_reset)
		begin
			state_next = RRG_IDLE;                // [R13]
			phase_next = RRG_PHASE1;              // [R16]
		end
		else
		begin
			unique case (state_reg)
				RRG_IDLE:
				begin
					if (START && (phase_reg == RRG_PHASE2))
					begin
						state_next = RRG_TS1;
						count_next = WAIT_COUNT;
						sys_next   = SYSTEM_BUS;
					end
				end
				RRG_TS1: state_next = RRG_TS2;
				RRG_TS2: state_next = RRG_TC1;
				RRG_TC1: state_next = RRG_TC2;
				RRG_TC2:
				begin
					if (!BUS.ready_n)
					begin
						state_next = RRG_IDLE;
						done_next  = 1'h1;
					end
					else
						state_next = RRG_TC1;
				end
				default: state_next = RRG_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Wait-state chain and ready inputs
	// ------------------------------------------------------------------

	// Stage 0 is set entering the first command state, each later stage
	// one command state after; ready low clears the chain.
	always_comb
	begin
		in_tc_next = (state_next == RRG_TC1) || (state_next == RRG_TC2);
		busy_next  = (state_next != RRG_IDLE);
		chain_next = chain_reg;
		if (!BUS.ready_n || (state_next == RRG_IDLE))
			chain_next = RRG_CHAIN_RESET;         // [R9]
		else if ((state_reg == RRG_TS2) && (state_next == RRG_TC1))
			chain_next = {chain_reg[RRG_CHAIN_LEN-1:1], 1'h1}; // [R9]
		else if ((state_reg == RRG_TC2) && (state_next == RRG_TC1))
			chain_next = {chain_reg[RRG_CHAIN_LEN-2:0], 1'h1}; // [R10]
		status_n_next  = ~((state_next == RRG_TS1) ||
			(state_next == RRG_TS2));
		sync_ready_in_n_next    = ~chain_next[count_next];  // [R10]
		sync_ready_in_en_n_next = sys_next | ~in_tc_next;  // [R11] [R3]
		async_ready_in_en_n_next = ~(sys_next & in_tc_next); // [R20] [R12]
	end

	// Registers sequencer, chain and every link output but the status high line.
	always_ff @(posedge CLOCK)
	begin
		if (RESET)
		begin
			state_reg     <= RRG_IDLE;
			phase_reg     <= RRG_PHASE1;
			chain_reg     <= RRG_CHAIN_RESET;
			count_reg     <= 2'h0;
			sys_reg       <= 1'h0;
			status_n_reg  <= 1'h1;
			sync_ready_in_n_reg    <= 1'h1;
			sync_ready_in_en_n_reg <= 1'h1;
			async_ready_in_en_n_reg <= 1'h1;
			xack_reg      <= 1'h1;
			done_reg      <= 1'h0;
			busy_reg      <= 1'h0;
		end
		else
		begin
			state_reg     <= state_next;
			phase_reg     <= phase_next;
			chain_reg     <= chain_next;
			count_reg     <= count_next;
			sys_reg       <= sys_next;
			status_n_reg  <= status_n_next;
			sync_ready_in_n_reg    <= sync_ready_in_n_next;
			sync_ready_in_en_n_reg <= sync_ready_in_en_n_next;
			async_ready_in_en_n_reg <= async_ready_in_en_n_next;
			xack_reg      <= XACK_N;              // [R12]
			done_reg      <= done_next;
			busy_reg      <= busy_next;
		end
	end

	// Link and user outputs, all from flip-flops except the status high line, which is tied high.
	assign BUS.bus_status_hi_n      = 1'h1;
	assign BUS.bus_status_lo_n      = status_n_reg;
	assign BUS.sync_ready_in_n      = sync_ready_in_n_reg;
	assign BUS.sync_ready_enable_n  = sync_ready_in_en_n_reg;
	assign BUS.async_ready_in_n     = xack_reg;
	assign BUS.async_ready_enable_n = async_ready_in_en_n_reg;
	assign BUSY                     = busy_reg;
	assign DONE                     = done_reg;

endmodule

// *** rrg_asserts.sv ***
// Checker for the ready and reset link between the two ends.
// Assumes the testbench places it beside the link interface.
`timescale 1ns/1ps

module rrg_asserts
(
	// Clock, reset and reset request pin.
	input wire logic CLOCK,
	input wire logic RESET,
	input wire logic RESET_REQUEST_N,
	// Link signals.
	input wire logic bus_status_hi_n,
	input wire logic bus_status_lo_n,
	input wire logic sync_ready_in_n,
	input wire logic sync_ready_enable_n,
	input wire logic async_ready_in_n,
	input wire logic async_ready_enable_n,
	input wire logic ready_n,
	input wire logic cpu_reset
);

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------

	// All checks run on the system clock and rest during reset.
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (RESET);

	a_reset_ready: assert property
		(cpu_reset && $past(cpu_reset) |-> !ready_n)
		else $error("ready line not low in reset");
	a_start_release: assert property
		($fell(bus_status_lo_n) || $fell(bus_status_hi_n) |-> ##[1:2] ready_n)
		else $error("ready line not released at cycle start");
	a_ready_held: assert property
		($fell(ready_n) |=> !ready_n)
		else $error("ready line dropped too early");
	a_sync_term: assert property
		($fell(sync_ready_in_n) && !sync_ready_enable_n |-> ##[1:3] !ready_n)
		else $error("sync ready did not end the cycle");
	a_async_term: assert property
		($fell(async_ready_in_n) && !async_ready_enable_n |-> ##[1:8] !ready_n)
		else $error("async ready did not end the cycle");
	a_wait_min: assert property
		($rose(ready_n) |-> ready_n [*2])
		else $error("cycle ended inside the status state");
	a_reset_rise: assert property
		($fell(RESET_REQUEST_N) |-> ##[1:2] cpu_reset)
		else $error("reset out late after request");
	a_reset_fall: assert property
		($rose(RESET_REQUEST_N) |-> cpu_reset ##[1:2] !cpu_reset)
		else $error("reset out release latency wrong");
	a_status_len: assert property
		($fell(bus_status_lo_n) |=> !bus_status_lo_n ##1 bus_status_lo_n)
		else $error("status state not two clocks");
	a_status_async: assert property
		(!bus_status_lo_n |-> async_ready_enable_n || async_ready_in_n)
		else $error("async ready active in status state");
	a_chain_clear: assert property
		($fell(ready_n) |=> sync_ready_in_n)
		else $error("wait chain not cleared by ready");
	a_enable_excl: assert property
		(!async_ready_enable_n |-> sync_ready_enable_n)
		else $error("sync ready enabled on a system-bus cycle");

endmodule

// *** rrg_test.sv ***
// Self-checking bench joining both ends of the ready and reset link.
// Assumes the package, interface, both ends and checker compile first.
`timescale 1ns/1ps

module rrg_test;

	// ----------------------------------------------------------------
	// Signals and instances
	// ----------------------------------------------------------------

	logic        clock;
	logic        reset;
	logic        reset_request_n;
	logic        start;
	logic [1:0]  wait_count;
	logic        system_bus;
	logic        xack_n;
	logic        periph_clk;
	logic        system_reset;
	logic        busy;
	logic        done;
	logic        pclk_last;
	logic [31:0] rnd;
	int          failures;
	int          checked;
	int          n;
	int          i;

	rrg_bus_if rrg_bus_if_i ();

	rrg_clockgen rrg_clockgen_i (.CLOCK(clock), .RESET(reset),
		.RESET_REQUEST_N(reset_request_n), .PERIPH_CLK(periph_clk),
		.SYSTEM_RESET(system_reset), .BUS(rrg_bus_if_i));

	rrg_cpu_end rrg_cpu_end_i (.CLOCK(clock), .RESET(reset),
		.START(start), .WAIT_COUNT(wait_count), .SYSTEM_BUS(system_bus),
		.XACK_N(xack_n), .BUSY(busy), .DONE(done), .BUS(rrg_bus_if_i));

	rrg_asserts rrg_asserts_i (.CLOCK(clock), .RESET(reset),
		.RESET_REQUEST_N(reset_request_n),
		.bus_status_hi_n(rrg_bus_if_i.bus_status_hi_n),
		.bus_status_lo_n(rrg_bus_if_i.bus_status_lo_n),
		.sync_ready_in_n(rrg_bus_if_i.sync_ready_in_n),
		.sync_ready_enable_n(rrg_bus_if_i.sync_ready_enable_n),
		.async_ready_in_n(rrg_bus_if_i.async_ready_in_n),
		.async_ready_enable_n(rrg_bus_if_i.async_ready_enable_n),
		.ready_n(rrg_bus_if_i.ready_n), .cpu_reset(rrg_bus_if_i.cpu_reset));

	// The system clock, 25 ns period.
	always #12.5 clock = ~clock;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------

	// Counts a comparison and reports a mismatch at once.
	task automatic check(input logic [31:0] seen, expected, input string msg);
		checked++;
		if (seen !== expected)
		begin
			failures++;
			$display("wrong value at %0t: %s (%0h, %0h)", $time, msg, seen,
				expected);
		end
	endtask

	// Prints the counts and the verdict, then stops the run.
	task automatic conclude();
		$display("checks %0d, failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Steps the repeatable random sequence.
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction

	// Clocks from the first status clock to the done pulse.
	function automatic int exp_len(input logic [1:0] w);
		return 4 + 2 * int'(w);
	endfunction

	// Runs one bus cycle; a system-bus cycle acknowledges after d clocks.
	task automatic run_cycle(input logic sb, input logic [1:0] w, input int d);
		int   k;
		logic last;
		k = 0;
		last = 1'h1;
		start = 1'h1;
		system_bus = sb;
		wait_count = w;
		while (rrg_bus_if_i.bus_status_lo_n !== 1'h0 && k < 20)
		begin
			@(negedge clock);
			k++;
		end
		start = 1'h0;
		check(k < 20, 1, "no cycle start");
		k = 0;
		while (done !== 1'h1 && k < 60)
		begin
			last = rrg_bus_if_i.ready_n;
			@(negedge clock);
			k++;
			if (k == 1)
				check(periph_clk, 1'h0, "clock not aligned");
			if (k == 2)
			begin
				check(rrg_bus_if_i.ready_n, 1, "ready not released");
				check(busy, 1, "busy not shown");
			end
			if (sb && k == d)
				xack_n = 1'h0;
		end
		check(last, 0, "ready not low before done");
		if (sb)
			check(k > d && k <= d + 10, 1, "system cycle length");
		else
			check(k, exp_len(w), "local cycle length");
		xack_n = 1'h1;
		system_bus = 1'h0;
		@(negedge clock);
		check(done, 0, "done longer than one clock");
		check(busy, 0, "busy after done");
	endtask

	// Holds the reset request, then checks the synchronised release.
	task automatic request_reset(input int hold);
		reset_request_n = 1'h0;
		repeat (hold) @(negedge clock);
		check(system_reset, 1, "reset out not raised");
		check(rrg_bus_if_i.ready_n, 0, "ready not low in reset");
		check(busy, 0, "busy in reset");
		reset_request_n = 1'h1;
		n = 0;
		while (system_reset !== 1'h0 && n < 10)
		begin
			@(negedge clock);
			n++;
		end
		check(n >= 1 && n <= 2, 1, "reset release latency");
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------

	// Resets, then runs corner cycles, random cycles and a second reset.
	initial
	begin
		clock = 1'h0;
		reset = 1'h1;
		reset_request_n = 1'h0;
		start = 1'h0;
		wait_count = 2'h0;
		system_bus = 1'h0;
		xack_n = 1'h1;
		rnd = 32'h03D36B53;
		failures = 0;
		checked = 0;
		repeat (3) @(negedge clock);
		reset = 1'h0;
		request_reset(34);
		for (i = 0; i < 4; i++)
			run_cycle(1'h0, i[1:0], 0);
		pclk_last = periph_clk;
		for (i = 0; i < 8; i++)
		begin
			@(negedge clock);
			check(periph_clk, !pclk_last, "peripheral clock stalled");
			pclk_last = periph_clk;
		end
		run_cycle(1'h1, 2'h0, 5);
		for (i = 0; i < 16; i++)
		begin
			rnd = xs(rnd);
			run_cycle(rnd[0], rnd[2:1], 3 + int'(rnd[5:3]));
		end
		request_reset(34);
		run_cycle(1'h0, 2'h3, 0);
		conclude();
	end

	// Cuts a hang short well beyond the few hundred clocks needed.
	initial
	begin
		repeat (20000) @(posedge clock);
		failures++;
		conclude();
	end

endmodule
